// file: common/uer_pkg.sv
// package: register map, field layout and bus timing of the usb status/error register bank
package uer_pkg;

   // ****************************************************************
   // register byte addresses
   // ****************************************************************
   localparam logic [7:0] ADDR_PACKET_ERROR_FLAGS    = 8'h39;
   localparam logic [7:0] ADDR_EP3_STATUS            = 8'h63;
   localparam logic [7:0] ADDR_EP4_PAYLOAD_SIZE_HIGH = 8'h6c;
   localparam logic [7:0] ADDR_EP5_PAYLOAD_SIZE_HIGH = 8'h6d;
   localparam logic [7:0] ADDR_EP4_RX_COUNT_HIGH     = 8'h74;
   localparam logic [7:0] ADDR_EP5_RX_COUNT_HIGH     = 8'h75;

   // ****************************************************************
   // field layout
   // ****************************************************************
   localparam int EP3_RX_READY_BIT  = 0;
   localparam int EP3_TX_READY_BIT  = 1;
   localparam int ERR_BIT_STUFF_BIT = 0;
   localparam int ERR_DATA_CRC_BIT  = 1;
   localparam int ERR_ADDR_CRC_BIT  = 2;
   localparam int ERR_PID_BIT       = 3;
   localparam int ERR_FLAG_COUNT    = 4;
   // upper bits of the 10-bit and 9-bit counts held in the high registers
   localparam int EP4_HIGH_BITS     = 2;
   localparam int EP5_HIGH_BITS     = 1;
   localparam int EP4_COUNT_BITS    = 10;
   localparam int EP5_COUNT_BITS    = 9;
   localparam int DATA_BITS         = 8;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [7:0] REG_RESET_VALUE = 8'h00;
   localparam logic [7:0] UNMAPPED_READ   = 8'h00;

   // ****************************************************************
   // bus timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS       = 50;
   localparam int FIFO_RECOVERY_NS    = 63;
   localparam int FIFO_ACCESS_NS      = 63;
   // least times: round up to whole cycles
   localparam int RECOVERY_CYCLES     = (FIFO_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACCESS_CYCLES       = (FIFO_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TIMER_BITS          = 3;

   typedef enum logic [1:0] {
      HOST_IDLE,
      HOST_ACCESS,
      HOST_RECOVER
   } uer_host_state_t;

endpackage

// file: common/uer_bus_if.sv
// interface: parallel register bus between the microcontroller and the usb device registers
`timescale 1ns/1ns
interface uer_bus_if;
   logic       cs_n;
   logic       rd_n;
   logic       wr_n;
   logic [7:0] addr;
   logic [7:0] host_dout;
   logic       host_oe;
   logic [7:0] dev_dout;
   logic       dev_oe;
   logic [7:0] data;

   // the shared data wire: whichever end enables drives it, idle reads as zero
   assign data = dev_oe ? dev_dout : (host_oe ? host_dout : 8'h00);

   modport device (
      input  cs_n,
      input  rd_n,
      input  wr_n,
      input  addr,
      input  data,
      output dev_dout,
      output dev_oe
   );

   modport host (
      output cs_n,
      output rd_n,
      output wr_n,
      output addr,
      output host_dout,
      output host_oe,
      input  data
   );
endinterface

// file: rtl/uer_host.sv
// module: microcontroller end, runs paced register reads and writes on the parallel bus
`timescale 1ns/1ns
module uer_host (
   input  wire logic       core_clk_i,
   input  wire logic       resetn_i,
   input  wire logic       req_i,
   input  wire logic       write_i,
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   output logic            ready_o,
   output logic [7:0]      rdata_o,
   output logic            rdata_valid_o,
   uer_bus_if.host         bus
);

   // ****************************************************************
   // state
   // ****************************************************************
   uer_pkg::uer_host_state_t               state_reg, state_next;
   logic [uer_pkg::TIMER_BITS-1:0]         timer_reg, timer_next;
   logic                                   write_reg, write_next;
   logic [7:0]                             addr_reg, addr_next;
   logic [7:0]                             wdata_reg, wdata_next;
   logic [7:0]                             rdata_reg, rdata_next;
   logic                                   valid_reg, valid_next;

   // the read sample needs one cycle for the device to register its answer
   if (uer_pkg::ACCESS_CYCLES < 2 || uer_pkg::ACCESS_CYCLES > 8 ||
       uer_pkg::RECOVERY_CYCLES < 1 || uer_pkg::RECOVERY_CYCLES > 8) begin : g_check
      $error("uer_host: access or recovery cycle count out of range");
   end

   always_comb begin
      state_next = state_reg;
      timer_next = timer_reg;
      write_next = write_reg;
      addr_next  = addr_reg;
      wdata_next = wdata_reg;
      rdata_next = rdata_reg;
      valid_next = 1'b0;
      case (state_reg)
         uer_pkg::HOST_IDLE: begin
            if (req_i) begin
               write_next = write_i;
               addr_next  = addr_i;
               wdata_next = wdata_i;
               timer_next = uer_pkg::TIMER_BITS'(uer_pkg::ACCESS_CYCLES - 1);
               state_next = uer_pkg::HOST_ACCESS;
            end
         end
         uer_pkg::HOST_ACCESS: begin
            // strobe held for the full access time
            if (timer_reg == '0) begin
               if (!write_reg) begin
                  rdata_next = bus.data;
                  valid_next = 1'b1;
               end
               timer_next = uer_pkg::TIMER_BITS'(uer_pkg::RECOVERY_CYCLES - 1);
               state_next = uer_pkg::HOST_RECOVER;
            end else begin
               timer_next = timer_reg - 1'b1;
            end
         end
         uer_pkg::HOST_RECOVER: begin
            // strobes stay idle for the recovery time before the next access
            if (timer_reg == '0) begin
               state_next = uer_pkg::HOST_IDLE;
            end else begin
               timer_next = timer_reg - 1'b1;
            end
         end
         default: begin
            state_next = uer_pkg::HOST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg <= uer_pkg::HOST_IDLE;
         timer_reg <= '0;
         write_reg <= 1'b0;
         addr_reg  <= 8'h00;
         wdata_reg <= 8'h00;
         rdata_reg <= 8'h00;
         valid_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         timer_reg <= timer_next;
         write_reg <= write_next;
         addr_reg  <= addr_next;
         wdata_reg <= wdata_next;
         rdata_reg <= rdata_next;
         valid_reg <= valid_next;
      end
   end

   // ****************************************************************
   // pins
   // ****************************************************************
   assign bus.cs_n      = (state_reg != uer_pkg::HOST_ACCESS);
   assign bus.rd_n      = !((state_reg == uer_pkg::HOST_ACCESS) && !write_reg);
   assign bus.wr_n      = !((state_reg == uer_pkg::HOST_ACCESS) && write_reg);
   assign bus.addr      = addr_reg;
   assign bus.host_dout = wdata_reg;
   assign bus.host_oe   = (state_reg == uer_pkg::HOST_ACCESS) && write_reg;

   assign ready_o       = (state_reg == uer_pkg::HOST_IDLE);
   assign rdata_o       = rdata_reg;
   assign rdata_valid_o = valid_reg;

endmodule // uer_host

// file: rtl/uer_device.sv
// module: device end, endpoint 3 status, endpoint 4/5 size and count highs, packet errors
`timescale 1ns/1ns
module uer_device (
   input  wire logic                               core_clk_i,
   input  wire logic                               resetn_i,
   uer_bus_if.device                               bus,
   input  wire logic                               usb_bus_reset_i,
   input  wire logic                               ep3_bulk_int_i,
   input  wire logic                               ep3_rx_good_i,
   input  wire logic                               ep3_out_data_i,
   input  wire logic                               ep3_in_token_i,
   input  wire logic                               ep3_host_ack_i,
   input  wire logic                               sop_i,
   input  wire logic                               err_bit_stuff_i,
   input  wire logic                               err_data_crc_i,
   input  wire logic                               err_addr_crc_i,
   input  wire logic                               err_pid_i,
   input  wire logic [uer_pkg::EP4_COUNT_BITS-1:0] ep4_rx_count_i,
   input  wire logic [uer_pkg::EP5_COUNT_BITS-1:0] ep5_rx_count_i,
   output logic                                    ep3_rx_locked_o,
   output logic                                    ep3_tx_enable_o,
   output logic                                    ep3_rx_accept_o,
   output logic                                    ep3_nak_o,
   output logic [uer_pkg::EP4_HIGH_BITS-1:0]       ep4_payload_size_high_o,
   output logic [uer_pkg::EP5_HIGH_BITS-1:0]       ep5_payload_size_high_o
);

   localparam int E4 = uer_pkg::EP4_HIGH_BITS;
   localparam int E5 = uer_pkg::EP5_HIGH_BITS;
   localparam int NF = uer_pkg::ERR_FLAG_COUNT;

   // ****************************************************************
   // state
   // ****************************************************************
   logic          wr_prev_reg, wr_prev_next;
   logic          rx_ready_reg, rx_ready_next;
   logic          tx_ready_reg, tx_ready_next;
   logic [E4-1:0] ep4_pld_reg, ep4_pld_next;
   logic [E5-1:0] ep5_pld_reg, ep5_pld_next;
   logic [E4-1:0] ep4_cnt_reg, ep4_cnt_next;
   logic [E5-1:0] ep5_cnt_reg, ep5_cnt_next;
   logic [NF-1:0] err_reg, err_next;
   logic [7:0]    rd_data_reg, rd_data_next;
   logic          nak_reg, nak_next;

   logic          wr_active;
   logic          rd_active;
   logic          wr_pulse;
   logic [7:0]    wdata;
   logic          rx_set;
   logic          rx_clr;
   logic          tx_set;
   logic          tx_clr;
   logic [NF-1:0] err_hit;
   logic [7:0]    status_word;
   logic [7:0]    err_word;

   if (uer_pkg::EP4_HIGH_BITS != uer_pkg::EP4_COUNT_BITS - uer_pkg::DATA_BITS ||
       uer_pkg::EP5_HIGH_BITS != uer_pkg::EP5_COUNT_BITS - uer_pkg::DATA_BITS) begin : g_check
      $error("uer_device: count widths do not match high register widths");
   end

   // ****************************************************************
   // bus decode
   // ****************************************************************
   // inputs are synchronous to the clock, so a write is taken once, on the strobe's first cycle
   assign wr_active = !bus.cs_n && !bus.wr_n;
   assign rd_active = !bus.cs_n && !bus.rd_n;
   assign wr_pulse  = wr_active && !wr_prev_reg;
   assign wdata     = bus.data;

   // ****************************************************************
   // event terms
   // ****************************************************************
   // ep3 events are ignored unless ep3 is in bulk or interrupt mode
   assign rx_set = ep3_bulk_int_i && ep3_rx_good_i && !rx_ready_reg;
   assign rx_clr = wr_pulse && (bus.addr == uer_pkg::ADDR_EP3_STATUS)
                   && wdata[uer_pkg::EP3_RX_READY_BIT];
   assign tx_set = wr_pulse && (bus.addr == uer_pkg::ADDR_EP3_STATUS)
                   && wdata[uer_pkg::EP3_TX_READY_BIT];
   assign tx_clr = ep3_bulk_int_i && ep3_host_ack_i && tx_ready_reg;

   assign err_hit[uer_pkg::ERR_BIT_STUFF_BIT] = err_bit_stuff_i;
   assign err_hit[uer_pkg::ERR_DATA_CRC_BIT]  = err_data_crc_i;
   assign err_hit[uer_pkg::ERR_ADDR_CRC_BIT]  = err_addr_crc_i;
   assign err_hit[uer_pkg::ERR_PID_BIT]       = err_pid_i;

   always_comb begin
      status_word = 8'h00;
      status_word[uer_pkg::EP3_RX_READY_BIT] = rx_ready_reg;
      status_word[uer_pkg::EP3_TX_READY_BIT] = tx_ready_reg;
      err_word = 8'h00;
      err_word[NF-1:0] = err_reg;
   end

   // ****************************************************************
   // next values
   // ****************************************************************
   always_comb begin
      wr_prev_next = wr_active;
      // a set in the same cycle as its clear wins, so no event is lost
      rx_ready_next = rx_set | (rx_ready_reg & ~rx_clr);
      tx_ready_next = tx_set | (tx_ready_reg & ~tx_clr);
      ep4_pld_next = ep4_pld_reg;
      ep5_pld_next = ep5_pld_reg;
      if (wr_pulse && bus.addr == uer_pkg::ADDR_EP4_PAYLOAD_SIZE_HIGH) begin
         ep4_pld_next = wdata[E4-1:0];
      end
      if (wr_pulse && bus.addr == uer_pkg::ADDR_EP5_PAYLOAD_SIZE_HIGH) begin
         ep5_pld_next = wdata[E5-1:0];
      end
      // count highs follow the receive counters; writes to them have no effect
      ep4_cnt_next = ep4_rx_count_i[uer_pkg::EP4_COUNT_BITS-1:uer_pkg::DATA_BITS];
      ep5_cnt_next = ep5_rx_count_i[uer_pkg::EP5_COUNT_BITS-1:uer_pkg::DATA_BITS];
      // an error detected with the start-of-packet belongs to the new packet
      err_next = (sop_i ? '0 : err_reg) | err_hit;
      nak_next = ep3_bulk_int_i && ((ep3_in_token_i && !tx_ready_reg) ||
                                    (ep3_out_data_i && rx_ready_reg));
      rd_data_next = uer_pkg::UNMAPPED_READ;
      if (rd_active) begin
         case (bus.addr)
            uer_pkg::ADDR_EP3_STATUS:            rd_data_next = status_word;
            uer_pkg::ADDR_PACKET_ERROR_FLAGS:    rd_data_next = err_word;
            uer_pkg::ADDR_EP4_PAYLOAD_SIZE_HIGH: rd_data_next = {{(8-E4){1'b0}}, ep4_pld_reg};
            uer_pkg::ADDR_EP5_PAYLOAD_SIZE_HIGH: rd_data_next = {{(8-E5){1'b0}}, ep5_pld_reg};
            uer_pkg::ADDR_EP4_RX_COUNT_HIGH:     rd_data_next = {{(8-E4){1'b0}}, ep4_cnt_reg};
            uer_pkg::ADDR_EP5_RX_COUNT_HIGH:     rd_data_next = {{(8-E5){1'b0}}, ep5_cnt_reg};
            default:                             rd_data_next = uer_pkg::UNMAPPED_READ;
         endcase
      end
      // a usb bus reset returns every register to zero
      if (usb_bus_reset_i) begin
         rx_ready_next = 1'b0;
         tx_ready_next = 1'b0;
         ep4_pld_next  = '0;
         ep5_pld_next  = '0;
         ep4_cnt_next  = '0;
         ep5_cnt_next  = '0;
         err_next      = '0;
         nak_next      = 1'b0;
      end
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         // hardware reset clears everything
         wr_prev_reg  <= 1'b0;
         rx_ready_reg <= 1'b0;
         tx_ready_reg <= 1'b0;
         ep4_pld_reg  <= '0;
         ep5_pld_reg  <= '0;
         ep4_cnt_reg  <= '0;
         ep5_cnt_reg  <= '0;
         err_reg      <= '0;
         rd_data_reg  <= uer_pkg::REG_RESET_VALUE;
         nak_reg      <= 1'b0;
      end else begin
         wr_prev_reg  <= wr_prev_next;
         rx_ready_reg <= rx_ready_next;
         tx_ready_reg <= tx_ready_next;
         ep4_pld_reg  <= ep4_pld_next;
         ep5_pld_reg  <= ep5_pld_next;
         ep4_cnt_reg  <= ep4_cnt_next;
         ep5_cnt_reg  <= ep5_cnt_next;
         err_reg      <= err_next;
         rd_data_reg  <= rd_data_next;
         nak_reg      <= nak_next;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   // the first read cycle shows the previous sample; the host samples late in the strobe
   assign bus.dev_dout = rd_data_reg;
   assign bus.dev_oe   = rd_active;

   assign ep3_rx_locked_o         = rx_ready_reg;
   assign ep3_rx_accept_o         = ep3_bulk_int_i && !rx_ready_reg;
   assign ep3_tx_enable_o         = ep3_bulk_int_i && tx_ready_reg;
   assign ep3_nak_o               = nak_reg;
   assign ep4_payload_size_high_o = ep4_pld_reg;
   assign ep5_payload_size_high_o = ep5_pld_reg;

endmodule // uer_device

// file: dv/uer_checker.sv
// checker: parallel register bus timing and read-back properties
`timescale 1ns/1ns
module uer_checker (
   input wire logic       core_clk_i,
   input wire logic       resetn_i,
   input wire logic       cs_n,
   input wire logic       rd_n,
   input wire logic       wr_n,
   input wire logic [7:0] addr,
   input wire logic [7:0] host_dout,
   input wire logic       host_oe,
   input wire logic [7:0] dev_dout,
   input wire logic       dev_oe,
   input wire logic [7:0] data
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);

   wire logic rd_act = !cs_n && !rd_n;

   // ****************************************************************
   // strobe timing
   // ****************************************************************
   chk_oe_on_read: assert property (dev_oe == rd_act)
      else $error("device drive enable differs from read strobe");
   chk_read_width: assert property ($fell(rd_n) |-> !cs_n ##1 rd_act ##1 rd_n)
      else $error("read strobe not held two cycles");
   chk_read_recovery: assert property ($rose(rd_n) |-> rd_n [*2])
      else $error("read recovery shorter than two cycles");
   chk_no_contention: assert property (!(dev_oe && host_oe))
      else $error("both ends drive the data wire");
   chk_write_width: assert property ($fell(wr_n) |-> host_oe ##1 (!wr_n && host_oe) ##1 wr_n)
      else $error("write strobe not held two cycles with data");
   chk_write_hold: assert property ((!wr_n && $past(!wr_n)) |-> $stable(host_dout) && $stable(addr))
      else $error("write data or address moved during strobe");

   // ****************************************************************
   // upper bits read back as zero once read data has settled
   // ****************************************************************
   chk_ep3_upper: assert property ((rd_act && $past(rd_act) && $stable(addr)
      && addr == uer_pkg::ADDR_EP3_STATUS) |-> dev_dout[7:2] == 6'h00)
      else $error("status upper bits not zero");
   chk_payload_upper: assert property ((rd_act && $past(rd_act) && $stable(addr)
      && (addr == uer_pkg::ADDR_EP4_PAYLOAD_SIZE_HIGH
          || addr == uer_pkg::ADDR_EP5_PAYLOAD_SIZE_HIGH))
      |-> dev_dout[7:2] == 6'h00
          && (addr != uer_pkg::ADDR_EP5_PAYLOAD_SIZE_HIGH || dev_dout[1] == 1'b0))
      else $error("payload size upper bits not zero");
   chk_count_upper: assert property ((rd_act && $past(rd_act) && $stable(addr)
      && (addr == uer_pkg::ADDR_EP4_RX_COUNT_HIGH
          || addr == uer_pkg::ADDR_EP5_RX_COUNT_HIGH))
      |-> dev_dout[7:2] == 6'h00
          && (addr != uer_pkg::ADDR_EP5_RX_COUNT_HIGH || dev_dout[1] == 1'b0))
      else $error("count upper bits not zero");
   chk_err_upper: assert property ((rd_act && $past(rd_act) && $stable(addr)
      && addr == uer_pkg::ADDR_PACKET_ERROR_FLAGS) |-> dev_dout[7:4] == 4'h0)
      else $error("error register upper bits not zero");

   cov_read: cover property ($fell(rd_n));
   cov_write: cover property ($fell(wr_n));
   cov_status_read: cover property (rd_act && addr == uer_pkg::ADDR_EP3_STATUS);
endmodule // uer_checker

// file: dv/tb_usb_ep_status_error_regs.sv
// testbench: host and device ends joined over the register bus
`timescale 1ns/1ns
module tb_usb_ep_status_error_regs;
   logic                               core_clk_i;
   logic                               resetn_i;
   logic                               req_i, write_i, ready_o, rdata_valid_o;
   logic [7:0]                         addr_i, wdata_i, rdata_o;
   logic                               usb_rst, bulk_int;
   logic [8:0]                         ev;
   logic [uer_pkg::EP4_COUNT_BITS-1:0] cnt4;
   logic [uer_pkg::EP5_COUNT_BITS-1:0] cnt5;
   logic                               locked, tx_en, accept, nak;
   logic [1:0]                         pl4;
   logic                               pl5;
   int                                 n_errors, n_compared;

   uer_bus_if bus_if ();
   uer_host i_uer_host (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .req_i(req_i),
      .write_i(write_i), .addr_i(addr_i), .wdata_i(wdata_i), .ready_o(ready_o),
      .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o), .bus(bus_if));
   uer_device i_uer_device (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .bus(bus_if),
      .usb_bus_reset_i(usb_rst), .ep3_bulk_int_i(bulk_int), .ep3_rx_good_i(ev[0]),
      .ep3_out_data_i(ev[1]), .ep3_in_token_i(ev[2]), .ep3_host_ack_i(ev[3]), .sop_i(ev[4]),
      .err_bit_stuff_i(ev[5]), .err_data_crc_i(ev[6]), .err_addr_crc_i(ev[7]),
      .err_pid_i(ev[8]), .ep4_rx_count_i(cnt4), .ep5_rx_count_i(cnt5),
      .ep3_rx_locked_o(locked), .ep3_tx_enable_o(tx_en), .ep3_rx_accept_o(accept),
      .ep3_nak_o(nak), .ep4_payload_size_high_o(pl4), .ep5_payload_size_high_o(pl5));
   uer_checker i_uer_checker (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
      .cs_n(bus_if.cs_n), .rd_n(bus_if.rd_n), .wr_n(bus_if.wr_n), .addr(bus_if.addr),
      .host_dout(bus_if.host_dout), .host_oe(bus_if.host_oe), .dev_dout(bus_if.dev_dout),
      .dev_oe(bus_if.dev_oe), .data(bus_if.data));

   initial begin
      core_clk_i = 1'b0;
      forever #25 core_clk_i = ~core_clk_i;
   end

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic end_sim();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one host command; waits bounded for ready and, on a read, for the data pulse
   task automatic bus_op(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int i;
      for (i = 0; i < 20 && ready_o !== 1'b1; i++) @(negedge core_clk_i);
      if (i == 20) begin
         n_errors++;
         end_sim();
      end
      @(posedge core_clk_i);
      req_i <= 1'b1;
      write_i <= wr;
      addr_i <= a;
      wdata_i <= d;
      @(posedge core_clk_i);
      req_i <= 1'b0;
      // leave the taking edge first, so that ready still shows its old value nowhere
      @(negedge core_clk_i);
      // a write has landed once the host is idle again; a read ends with the data pulse
      for (i = 0; i < 20 && (wr ? ready_o : rdata_valid_o) !== 1'b1; i++)
         @(negedge core_clk_i);
      if (i == 20) begin
         n_errors++;
         end_sim();
      end
   endtask

   task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
      bus_op(1'b0, a, 8'h00);
      check($sformatf("reg %h", a), rdata_o, exp);
   endtask

   // one-cycle event pulse, then settle past the registering edge
   task automatic pulse(input int n);
      @(posedge core_clk_i);
      ev[n] <= 1'b1;
      @(posedge core_clk_i);
      ev[n] <= 1'b0;
      @(negedge core_clk_i);
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset_values();
      chk_rd(8'h39, 8'h00);
      chk_rd(8'h63, 8'h00);
      chk_rd(8'h6c, 8'h00);
      chk_rd(8'h6d, 8'h00);
      chk_rd(8'h74, 8'h00);
      chk_rd(8'h75, 8'h00);
      chk_rd(8'h50, uer_pkg::UNMAPPED_READ);
   endtask

   task automatic t_ep3_receive();
      pulse(0);
      check("locked", {7'h0, locked}, 8'h01);
      check("accept", {7'h0, accept}, 8'h00);
      pulse(1);
      check("nak out", {7'h0, nak}, 8'h01);
      bus_op(1'b1, 8'h63, 8'h00);
      chk_rd(8'h63, 8'h01);
      bus_op(1'b1, 8'h63, 8'h01);
      chk_rd(8'h63, 8'h00);
      check("accept again", {7'h0, accept}, 8'h01);
      pulse(1);
      check("no nak out", {7'h0, nak}, 8'h00);
   endtask

   task automatic t_ep3_transmit();
      pulse(2);
      check("nak in", {7'h0, nak}, 8'h01);
      check("tx off", {7'h0, tx_en}, 8'h00);
      bus_op(1'b1, 8'h63, 8'h02);
      check("tx on", {7'h0, tx_en}, 8'h01);
      chk_rd(8'h63, 8'h02);
      bus_op(1'b1, 8'h63, 8'h00);
      chk_rd(8'h63, 8'h02);
      pulse(2);
      check("no nak in", {7'h0, nak}, 8'h00);
      pulse(3);
      check("tx cleared", {7'h0, tx_en}, 8'h00);
      chk_rd(8'h63, 8'h00);
   endtask

   task automatic t_ep3_other_mode();
      @(posedge core_clk_i);
      bulk_int <= 1'b0;
      pulse(0);
      check("accept off", {7'h0, accept}, 8'h00);
      chk_rd(8'h63, 8'h00);
      @(posedge core_clk_i);
      bulk_int <= 1'b1;
   endtask

   task automatic t_sizes_counts();
      bus_op(1'b1, 8'h6c, 8'hff);
      chk_rd(8'h6c, 8'h03);
      bus_op(1'b1, 8'h6d, 8'hff);
      chk_rd(8'h6d, 8'h01);
      check("pl out", {5'h0, pl4, pl5}, 8'h07);
      @(posedge core_clk_i);
      cnt4 <= 10'h2a5;
      cnt5 <= 9'h1f3;
      bus_op(1'b1, 8'h74, 8'hff);
      chk_rd(8'h74, 8'h02);
      chk_rd(8'h75, 8'h01);
   endtask

   task automatic t_errors();
      logic [7:0] exp;
      exp = 8'h00;
      for (int i = 0; i < uer_pkg::ERR_FLAG_COUNT; i++) begin
         pulse(5 + i);
         exp[i] = 1'b1;
         chk_rd(8'h39, exp);
      end
      bus_op(1'b1, 8'h39, 8'h00);
      chk_rd(8'h39, 8'h0f);
      pulse(4);
      chk_rd(8'h39, 8'h00);
   endtask

   task automatic t_bus_reset();
      bus_op(1'b1, 8'h63, 8'h02);
      pulse(0);
      pulse(5);
      @(posedge core_clk_i);
      cnt4 <= 10'h000;
      cnt5 <= 9'h000;
      usb_rst <= 1'b1;
      @(posedge core_clk_i);
      usb_rst <= 1'b0;
      chk_rd(8'h63, 8'h00);
      chk_rd(8'h6c, 8'h00);
      chk_rd(8'h6d, 8'h00);
      chk_rd(8'h39, 8'h00);
      chk_rd(8'h74, 8'h00);
   endtask

   initial begin
      n_errors = 0;
      n_compared = 0;
      resetn_i = 1'b0;
      req_i = 1'b0;
      write_i = 1'b0;
      addr_i = 8'h00;
      wdata_i = 8'h00;
      usb_rst = 1'b0;
      bulk_int = 1'b1;
      ev = 9'h000;
      cnt4 = 10'h000;
      cnt5 = 9'h000;
      repeat (6) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      t_reset_values();
      t_ep3_receive();
      t_ep3_transmit();
      t_ep3_other_mode();
      t_sizes_counts();
      t_errors();
      t_bus_reset();
      end_sim();
   end
endmodule // tb_usb_ep_status_error_regs
